// >>> rtl/dsleep_gate_defs.svh
`ifndef DSLEEP_GATE_DEFS_SVH
`define DSLEEP_GATE_DEFS_SVH
`define SYSCTL_BASE 32'h400fe000
`define DSLEEP_GATE_OFFSET 12'h120
`define GATE_STATUS_OFFSET 12'h200
`define GATE_MASK_OFFSET 12'h204
`define RUN_GATE_OFFSET 12'h208
`define GATE_CONFIG_OFFSET 12'h20c
`define DSLEEP_GATE_RESET 32'h00000040
`define DSLEEP_GATE_WMASK 32'h13130f48
`define BIT_SECOND_WATCHDOG 28
`define BIT_SECOND_CAN 25
`define BIT_FIRST_CAN 24
`define BIT_PWM 20
`define BIT_SECOND_CONV 17
`define BIT_FIRST_CONV 16
`define BIT_HIBERNATION 6
`define BIT_FIRST_WATCHDOG 3
`define SPEED_SECOND_LSB 10
`define SPEED_FIRST_LSB 8
`define SPEED_1MSPS 2'h3
`define SIZE_WORD 3'h2
`define GATE_VEC_RESET 8'h02
`define NUM_GATES 8
`define EVT_FAULT 0
`define EVT_BAD_SPEED 1
`define NUM_EVENTS 2
`endif

// >>> rtl/dsleep_gate_pkg.sv
package dsleep_gate_pkg;
  typedef logic [7:0] gate_vec_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_err1 = 2'b01,
    st_err2 = 2'b10
  } bus_state_t;
endpackage

// >>> rtl/dsleep_gate_ctrl.sv
`timescale 1ns/1ps
`include "dsleep_gate_defs.svh"
// How it works
// - In deep sleep with auto gating selected each implemented gating bit is the clock enable of its module.
// - An access to a peripheral whose enable is clear is answered with a bus fault.
// - The gating register decodes at offset 0x120 from base 0x400fe000.
// - The register reads 0x00000040 after reset.
// - All other gating bits reset clear, leaving those modules unclocked.
// - Bit 28 enables the second watchdog clock.
// - Bit 25 enables the second CAN controller clock.
// - Bit 24 enables the first CAN controller clock.
// - Bit 20 enables the PWM unit clock.
// - Bits 17 and 16 enable the second and first converter clocks.
// - Bits 11:10 and 9:8 hold converter speed limits where 0x3 means one million samples per second.
// - Reserved bits are read-only and read zero.
// - Deep-sleep gating applies only when auto gating is selected, else run gating applies.
// - Bit 6 enables the hibernation module clock.
// - Bit 3 enables the first watchdog clock.
module dsleep_gate_ctrl
  import dsleep_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic deep_sleep,
  input wire logic periph_access,
  input wire logic [2:0] periph_sel,
  output logic periph_fault,
  output logic [7:0] module_clk_en,
  output logic [7:0] module_clk,
  output logic [1:0] first_converter_speed_limit,
  output logic [1:0] second_converter_speed_limit,
  output logic irq
);
  logic [31:0] gate_q;
  logic [31:0] run_gate_q;
  logic auto_sleep_gating_select_q;
  logic [`NUM_EVENTS-1:0] status_q;
  logic [`NUM_EVENTS-1:0] mask_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;
  bus_state_t state_q;
  logic deep_q;
  logic deep_s1_q;
  logic acc_s1_q;
  logic acc_q;
  logic [2:0] sel_q;
  logic [2:0] sel_s1_q;
  logic [7:0] en_latch;
  logic fault_q;
  logic in_range;
  logic addr_ok;
  logic take;
  logic [11:0] off;
  logic [31:0] rd_val;
  gate_vec_t dsleep_vec;
  gate_vec_t run_vec;
  gate_vec_t eff_vec;
  logic [`NUM_EVENTS-1:0] evt;
  logic bad_speed;
  logic aligned;
  logic word_size;
  logic off_hit;
  logic rd_take;
  logic wr_gate;
  logic wr_run;
  logic wr_cfg;
  logic wr_mask;
  logic wr_status;
  logic [31:0] gate_d;
  logic [31:0] run_gate_d;
  logic auto_sleep_gating_select_d;
  logic [`NUM_EVENTS-1:0] mask_d;
  logic [`NUM_EVENTS-1:0] status_d;
  gate_vec_t module_clk_en_d;
  logic fault_d;

  // Base kept full width so the page compare slices it on purpose
  localparam logic [31:0] sys_base = `SYSCTL_BASE;

  function automatic gate_vec_t pick_gates(input logic [31:0] r);
    gate_vec_t v;
    v = '0;
    v[7] = r[`BIT_SECOND_WATCHDOG];
    v[6] = r[`BIT_SECOND_CAN];
    v[5] = r[`BIT_FIRST_CAN];
    v[4] = r[`BIT_PWM];
    v[3] = r[`BIT_SECOND_CONV];
    v[2] = r[`BIT_FIRST_CONV];
    v[1] = r[`BIT_HIBERNATION];
    v[0] = r[`BIT_FIRST_WATCHDOG];
    return v;
  endfunction

  function automatic logic speed_bad(input logic [1:0] s);
    return (s != 2'h0) && (s != `SPEED_1MSPS);
  endfunction

  // Only word accesses to the five registers complete without error
  function automatic logic reg_mapped(input logic [11:0] o);
    logic hit;
    hit = 1'b0;
    case (o)
      `DSLEEP_GATE_OFFSET, `GATE_STATUS_OFFSET, `GATE_MASK_OFFSET: hit = 1'b1;
      `RUN_GATE_OFFSET, `GATE_CONFIG_OFFSET: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic wr_to(input logic pend, input logic [11:0] a, input logic [11:0] o);
    return pend && (a == o);
  endfunction

  assign in_range = (haddr[31:12] == sys_base[31:12]);
  assign off = haddr[11:0];
  assign aligned = (haddr[1:0] == 2'h0);
  assign word_size = (hsize == `SIZE_WORD);
  assign off_hit = reg_mapped(off);
  assign addr_ok = in_range && aligned && word_size && off_hit;
  // Last error cycle has hready high, so a new address phase may start there
  assign take = hsel && hready && htrans[1] && (state_q != st_err1);
  assign rd_take = take && addr_ok && !hwrite;

  assign wr_gate = wr_to(wr_pend_q, wr_addr_q, `DSLEEP_GATE_OFFSET);
  assign wr_run = wr_to(wr_pend_q, wr_addr_q, `RUN_GATE_OFFSET);
  assign wr_cfg = wr_to(wr_pend_q, wr_addr_q, `GATE_CONFIG_OFFSET);
  assign wr_mask = wr_to(wr_pend_q, wr_addr_q, `GATE_MASK_OFFSET);
  assign wr_status = wr_to(wr_pend_q, wr_addr_q, `GATE_STATUS_OFFSET);

  // Next values, so a read right behind a write already sees the written data
  assign gate_d = wr_gate ? (hwdata & `DSLEEP_GATE_WMASK) : gate_q;
  assign run_gate_d = wr_run ? (hwdata & `DSLEEP_GATE_WMASK) : run_gate_q;
  assign auto_sleep_gating_select_d = wr_cfg ? hwdata[0] : auto_sleep_gating_select_q;
  assign mask_d = wr_mask ? hwdata[`NUM_EVENTS-1:0] : mask_q;

  always_comb begin
    rd_val = 32'h0;
    case (off)
      `DSLEEP_GATE_OFFSET: rd_val = gate_d;
      `GATE_STATUS_OFFSET: rd_val = {30'h0, status_d};
      `GATE_MASK_OFFSET: rd_val = {30'h0, mask_d};
      `RUN_GATE_OFFSET: rd_val = run_gate_d;
      `GATE_CONFIG_OFFSET: rd_val = {31'h0, auto_sleep_gating_select_d};
      default: rd_val = 32'h0;
    endcase
  end

  // Bus state: unmapped access gets the two-cycle error response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else if (clk_en) begin
      case (state_q)
        st_idle: state_q <= (take && !addr_ok) ? st_err1 : st_idle;
        st_err1: state_q <= st_err2;
        st_err2: state_q <= (take && !addr_ok) ? st_err1 : st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // Write data arrives one cycle after its address, so the write is remembered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= take && addr_ok && hwrite;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_addr_q <= 12'h0;
    end else if (clk_en && take) begin
      wr_addr_q <= off;
    end
  end

  // Read data is taken at the address phase and stands until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0;
    end else if (clk_en && rd_take) begin
      hrdata_q <= rd_val;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = (state_q != st_err1);
  assign hresp = (state_q != st_idle);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q <= `DSLEEP_GATE_RESET;
    end else if (clk_en) begin
      gate_q <= gate_d;
    end
  end

  // Run gate shares the layout and reset of the deep-sleep gate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_gate_q <= `DSLEEP_GATE_RESET;
    end else if (clk_en) begin
      run_gate_q <= run_gate_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_sleep_gating_select_q <= 1'b0;
    end else if (clk_en) begin
      auto_sleep_gating_select_q <= auto_sleep_gating_select_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (clk_en) begin
      mask_q <= mask_d;
    end
  end

  assign first_converter_speed_limit = gate_q[`SPEED_FIRST_LSB +: 2];
  assign second_converter_speed_limit = gate_q[`SPEED_SECOND_LSB +: 2];
  // Speed code other than 0 or 1 Msps is flagged, the stored value still drives the converter
  assign bad_speed = wr_pend_q && (wr_addr_q == `DSLEEP_GATE_OFFSET) &&
                     (speed_bad(hwdata[`SPEED_FIRST_LSB +: 2]) || speed_bad(hwdata[`SPEED_SECOND_LSB +: 2]));

  // Sleep request and peripheral access come from outside, synchronised first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deep_s1_q <= 1'b0;
      deep_q <= 1'b0;
    end else if (clk_en) begin
      deep_s1_q <= deep_sleep;
      deep_q <= deep_s1_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_s1_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (clk_en) begin
      acc_s1_q <= periph_access;
      acc_q <= acc_s1_q;
    end
  end

  // Select must be steady before the access strobe rises; it is not gray coded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_s1_q <= 3'h0;
      sel_q <= 3'h0;
    end else if (clk_en) begin
      sel_s1_q <= periph_sel;
      sel_q <= sel_s1_q;
    end
  end

  assign dsleep_vec = pick_gates(gate_q);
  assign run_vec = pick_gates(run_gate_q);
  assign eff_vec = (deep_q && auto_sleep_gating_select_q) ? dsleep_vec : run_vec;

  assign module_clk_en_d = eff_vec;
  assign fault_d = acc_q && !eff_vec[sel_q];

  // Reset value follows the run gate reset, so the hibernation clock starts on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_clk_en <= `GATE_VEC_RESET;
    end else if (clk_en) begin
      module_clk_en <= module_clk_en_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (clk_en) begin
      fault_q <= fault_d;
    end
  end

  assign periph_fault = fault_q;

  // Latch is open while clk is low so the enable never changes during a high phase
  always_latch begin
    if (!clk) begin
      en_latch <= module_clk_en;
    end
  end

  assign module_clk = {8{clk}} & en_latch;

  assign evt[`EVT_FAULT] = clk_en && fault_q;
  assign evt[`EVT_BAD_SPEED] = clk_en && bad_speed;

  // Set beats a same-cycle write-one clear
  always_comb begin
    status_d = status_q | evt;
    if (wr_status) begin
      status_d = (status_q & ~hwdata[`NUM_EVENTS-1:0]) | evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else if (clk_en) begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

// >>> tb/gate_checker.sv
`timescale 1ns/1ps
module gate_checker(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic periph_access,
  input wire logic [2:0] periph_sel,
  input wire logic periph_fault,
  input wire logic [7:0] module_clk_en,
  input wire logic [1:0] first_converter_speed_limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic req;
  logic [1:0] wspd;
  // Bench ties hready to hreadyout, so one signal serves both
  assign req = hsel && htrans[1] && hreadyout && clk_en && hsize == 3'h2;
  assign wspd = hwdata[9:8];
  chk_map_ok: assert property (req && haddr == 32'h400fe120 |=> hreadyout && !hresp)
    else $error("mapped access not okay");
  chk_map_err: assert property (req && haddr == 32'h400fe124 |=> !hreadyout && hresp)
    else $error("unmapped access not refused");
  chk_err_one: assert property (!hreadyout |=> hreadyout && hresp)
    else $error("error response too long");
  chk_err_resp: assert property (!hreadyout |-> hresp)
    else $error("wait state without error");
  chk_rst_gate: assert property ($fell(rst) |-> module_clk_en == 8'h02)
    else $error("gate enables wrong after reset");
  chk_rst_speed: assert property ($fell(rst) |-> first_converter_speed_limit == 2'h0)
    else $error("speed limit wrong after reset");
  chk_speed_wr: assert property (req && hwrite && haddr == 32'h400fe120 |-> ##2 first_converter_speed_limit == $past(wspd))
    else $error("speed limit not written");
  chk_gate_fault: assert property ($rose(periph_access) && !module_clk_en[periph_sel] |-> ##[2:5] periph_fault)
    else $error("gated access gave no fault");
  cover property (req && !hwrite && haddr == 32'h400fe120);
  cover property ($rose(periph_fault));
  cover property (!hreadyout);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, clk_en, hsel, hwrite, hready, hreadyout, hresp, deep_sleep, periph_access, periph_fault, irq, dp, rd;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, first_converter_speed_limit, second_converter_speed_limit;
  logic [2:0] hsize, periph_sel;
  logic [7:0] module_clk_en, module_clk;
  logic [15:0] s;
  logic [32:0] q[$];
  int failures, n_tests;
  int pos[8] = '{3, 6, 16, 17, 20, 24, 25, 28};
  dsleep_gate_ctrl dsleep_gate_ctrl_inst(.*);
  assign hready = hreadyout;
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task results;
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [32:0] v, input logic [32:0] e);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, v, e);
    end
  endtask
  task wt;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i == 50) begin
      failures++;
      results;
    end
  endtask
  task xfer(input logic w, input logic [11:0] o, input logic [31:0] v, input logic [32:0] e);
    q.push_back(e);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'h400fe000 + o;
    wt;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= v;
    wt;
  endtask
  // Read data only matters on an okay read; error data is undefined
  always @(posedge clk) begin
    if (dp && hreadyout === 1'b1) chk({hresp, rd && !hresp ? hrdata : 32'h0}, q.pop_front());
    if (hreadyout === 1'b1) begin
      dp <= hsel && htrans[1];
      rd <= !hwrite;
    end
  end
  initial begin
    {rst, clk_en, hsize, s} = {1'b1, 1'b1, 3'h2, 16'h6c65};
    {hsel, haddr, htrans, hwrite, hwdata, deep_sleep, periph_access, periph_sel, dp, rd} = '0;
    {failures, n_tests} = '0;
    repeat (6) @(posedge clk);
    rst <= 0;
    xfer(0, 12'h120, 0, 33'h40);
    chk(module_clk_en, 8'h02);
    xfer(0, 12'h124, 0, 33'h100000000);
    hsize <= 3'h0;
    xfer(0, 12'h120, 0, 33'h100000000);
    hsize <= 3'h2;
    xfer(1, 12'h120, 32'hffffffff, 0);
    xfer(0, 12'h120, 0, 33'h13130f48);
    for (int k = 0; k < 4; k++) begin
      s = lfsr(s);
      d[31:16] = s;
      s = lfsr(s);
      d[15:0] = s;
      xfer(1, 12'h120, d, 0);
      xfer(0, 12'h120, 0, {1'b0, d & 32'h13130f48});
      chk({second_converter_speed_limit, first_converter_speed_limit}, d[11:8]);
    end
    xfer(1, 12'h20c, 1, 0);
    deep_sleep <= 1;
    // Gate k alone enabled: peripheral k must answer, peripheral k+1 (peripheral 0 after gate 7) must fault
    for (int k = 0; k < 8; k++) begin
      xfer(1, 12'h120, 32'h1 << pos[k], 0);
      repeat (4) @(posedge clk);
      chk(module_clk_en, 8'h1 << k);
      #1 chk(module_clk, 8'h1 << k);
      @(posedge clk);
      periph_sel <= 3'(k);
      periph_access <= 1;
      repeat (6) @(posedge clk);
      chk(periph_fault, 0);
      periph_access <= 0;
      repeat (4) @(posedge clk);
      periph_sel <= 3'(k + 1);
      periph_access <= 1;
      for (int i = 0; i < 8 && periph_fault !== 1'b1; i++) @(posedge clk);
      chk(periph_fault, 1);
      periph_access <= 0;
      repeat (5) @(posedge clk);
    end
    clk_en <= 0;
    deep_sleep <= 0;
    repeat (4) @(posedge clk);
    chk(module_clk_en, 8'h80);
    clk_en <= 1;
    deep_sleep <= 1;
    xfer(1, 12'h200, 32'h3, 0);
    xfer(1, 12'h120, 32'h100, 0);
    xfer(0, 12'h200, 0, 33'h2);
    chk(irq, 0);
    xfer(1, 12'h204, 3, 0);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    xfer(1, 12'h200, 32'h3, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    xfer(1, 12'h20c, 0, 0);
    repeat (4) @(posedge clk);
    chk(module_clk_en, 8'h02);
    results;
  end
endmodule
bind dsleep_gate_ctrl gate_checker gate_checker_inst(.*);
